// File: design/dio_pkg.sv
// package: constants and types for the digital i/o process data port
// Summary of operation
// [R1] general purpose width is 0, 1, 2, 4 or 8 bytes
// [R2] gp inputs and outputs share that width
// [R3] gp i/o present with any interface choice
// [R4] no interface leaves only gp i/o path
// [R5] digital i/o port is 1 to 4 bytes
// [R6] each byte independently input or output
// [R7] sof mode samples inputs just before insertion
// [R8] external mode samples on application strobe
// [R9] sync modes sample on sync pulse zero/one
// [R10] eof mode updates outputs on error-free frame
// [R11] sync output modes need distributed clocks enabled
// [R12] emulation option sets config bit 0 of 0x0141
// [R13] outputs hold; capture never touches output bytes
package dio_pkg;
  localparam int DIO_MAX_BYTES = 4;
  localparam int DIO_GP_MAX_BYTES = 8;
  localparam logic [15:0] DIO_EMUL_REG_OFFSET = 16'h0141;
  localparam int DIO_EMUL_BIT = 0;
  localparam logic [7:0] DIO_OUT_RESET = 8'h00;
  localparam logic [7:0] DIO_IN_RESET = 8'h00;

  typedef enum logic [1:0] {
    DIO_PDI_NONE = 2'h0,
    DIO_PDI_DIGITAL = 2'h1,
    DIO_PDI_OTHER = 2'h3
  } dio_pdi_t;

  typedef enum logic [1:0] {
    DIO_IN_SOF = 2'h0,
    DIO_IN_EXT = 2'h1,
    DIO_IN_DC_SYNC_PULSE_ZERO = 2'h3,
    DIO_IN_DC_SYNC_PULSE_ONE = 2'h2
  } dio_in_mode_t;

  typedef enum logic [1:0] {
    DIO_OUT_EOF = 2'h0,
    DIO_OUT_DC_SYNC_PULSE_ZERO = 2'h1,
    DIO_OUT_DC_SYNC_PULSE_ONE = 2'h3
  } dio_out_mode_t;

  typedef struct packed {
    logic sof;
    logic insert_soon;
    logic eof;
    logic frame_ok;
  } dio_frame_t;

  typedef struct packed {
    logic dc_sync_pulse_zero;
    logic dc_sync_pulse_one;
  } dio_sync_t;
endpackage

// File: design/dio_sync3.sv
// three-stage input synchroniser with agreement filter
`timescale 1ns/1ps
module dio_sync3 #(
  parameter int WIDTH = 1
) (
  input  wire logic             i_clk,
  input  wire logic             i_rst_b,
  input  wire logic [WIDTH-1:0] i_async,
  output logic      [WIDTH-1:0] o_sync
);
  logic [WIDTH-1:0] meta;
  logic [WIDTH-1:0] s2;
  logic [WIDTH-1:0] s3;
  logic [WIDTH-1:0] next_o_sync;

  // a change counts only once stage two and three agree
  assign next_o_sync = (s2 == s3) ? s3 : o_sync;

  always_ff @(posedge i_clk or negedge i_rst_b)
  begin
    if (!i_rst_b)
    begin
      meta <= '0;
      s2 <= '0;
      s3 <= '0;
      o_sync <= '0;
    end
    else
    begin
      meta <= i_async;
      s2 <= meta;
      s3 <= s2;
      o_sync <= next_o_sync;
    end
  end
endmodule

// File: design/dio_byte_reg.sv
// one byte register with load enable, reset to a constant
`timescale 1ns/1ps
module dio_byte_reg
  import dio_pkg::*;
(
  input  wire logic       i_clk,
  input  wire logic       i_rst_b,
  input  wire logic       i_load,
  input  wire logic [7:0] i_data,
  output logic      [7:0] o_data
);
  always_ff @(posedge i_clk or negedge i_rst_b)
  begin
    if (!i_rst_b)
      o_data <= DIO_OUT_RESET;
    else if (i_load)
      o_data <= i_data;
  end
endmodule

// File: design/dio_port.sv
// digital i/o process data port with general purpose i/o
`timescale 1ns/1ps
module dio_port
  import dio_pkg::*;
#(
  parameter int                  NUM_BYTES    = DIO_MAX_BYTES,
  parameter logic [3:0]          BYTE_IS_OUT  = 4'h8,
  parameter int                  GP_BYTES     = DIO_GP_MAX_BYTES,
  parameter dio_pkg::dio_pdi_t   PDI_SEL      = DIO_PDI_DIGITAL,
  parameter dio_pkg::dio_in_mode_t  IN_MODE   = DIO_IN_SOF,
  parameter dio_pkg::dio_out_mode_t OUT_MODE  = DIO_OUT_EOF,
  parameter bit                  DC_ENABLED   = 1'b1,
  parameter bit                  DEVICE_EMUL  = 1'b0
) (
  input  wire logic                   i_clk,
  input  wire logic                   i_rst_b,
  input  wire dio_pkg::dio_frame_t    i_frame,
  input  wire dio_pkg::dio_sync_t     i_sync,
  input  wire logic                   i_external_input_capture_strobe,
  input  wire logic [8*DIO_MAX_BYTES-1:0] i_pin,
  input  wire logic [8*DIO_MAX_BYTES-1:0] i_frame_out_data,
  output logic      [8*DIO_MAX_BYTES-1:0] o_pin,
  output logic      [DIO_MAX_BYTES-1:0]   o_pin_oe,
  output logic      [8*DIO_MAX_BYTES-1:0] o_frame_in_data,
  output logic                        o_in_captured,
  output logic                        o_out_updated,
  input  wire logic [8*DIO_GP_MAX_BYTES-1:0] i_gp_in,
  input  wire logic [8*DIO_GP_MAX_BYTES-1:0] i_gp_out_data,
  output logic      [8*DIO_GP_MAX_BYTES-1:0] o_gp_in_data,
  output logic      [8*DIO_GP_MAX_BYTES-1:0] o_gp_out,
  output logic      [7:0]             o_emul_cfg
);
  localparam bit DIO_ACTIVE = (PDI_SEL == DIO_PDI_DIGITAL);
  localparam logic [3:0] BYTE_USED = 4'((1 << NUM_BYTES) - 1);

  initial
  begin
    // build-time checks of legal sizes
    if (NUM_BYTES < 1 || NUM_BYTES > DIO_MAX_BYTES)
      $error("digital i/o size must be 1 to 4 bytes"); // [R5]
    if (!(GP_BYTES == 0 || GP_BYTES == 1 || GP_BYTES == 2 || GP_BYTES == 4 || GP_BYTES == 8))
      $error("gp width must be 0, 1, 2, 4 or 8 bytes"); // [R1]
  end

  logic [8*DIO_MAX_BYTES-1:0] pin_s;
  logic [8*DIO_GP_MAX_BYTES-1:0] gp_s;
  logic [2:0] ev_s;
  logic strobe_s;
  logic dc_sync_pulse_zero_s;
  logic dc_sync_pulse_one_s;
  logic [2:0] ev_d;

  dio_sync3 #(.WIDTH(8*DIO_MAX_BYTES)) u_pin_sync (
    .i_clk   (i_clk),
    .i_rst_b (i_rst_b),
    .i_async (i_pin),
    .o_sync  (pin_s)
  );

  dio_sync3 #(.WIDTH(8*DIO_GP_MAX_BYTES)) u_gp_sync (
    .i_clk   (i_clk),
    .i_rst_b (i_rst_b),
    .i_async (i_gp_in),
    .o_sync  (gp_s)
  );

  // strobe and sync pulses come from outside the core clock
  dio_sync3 #(.WIDTH(3)) u_ev_sync (
    .i_clk   (i_clk),
    .i_rst_b (i_rst_b),
    .i_async ({i_external_input_capture_strobe, i_sync.dc_sync_pulse_zero, i_sync.dc_sync_pulse_one}),
    .o_sync  (ev_s)
  );

  always_ff @(posedge i_clk or negedge i_rst_b)
  begin
    if (!i_rst_b)
      ev_d <= 3'h0;
    else
      ev_d <= ev_s;
  end

  // rising edges after filtering
  assign strobe_s = ev_s[2] & ~ev_d[2];
  assign dc_sync_pulse_zero_s = ev_s[1] & ~ev_d[1];
  assign dc_sync_pulse_one_s = ev_s[0] & ~ev_d[0];

  logic capture;
  logic update;
  assign capture = DIO_ACTIVE &&
    ((IN_MODE == DIO_IN_SOF   && i_frame.insert_soon) || // [R7]
     (IN_MODE == DIO_IN_EXT   && strobe_s) || // [R8]
     (IN_MODE == DIO_IN_DC_SYNC_PULSE_ZERO && dc_sync_pulse_zero_s) || // [R9]
     (IN_MODE == DIO_IN_DC_SYNC_PULSE_ONE && dc_sync_pulse_one_s)); // [R9]
  // sync output modes are dead without distributed clocks
  assign update = DIO_ACTIVE &&
    ((OUT_MODE == DIO_OUT_EOF && i_frame.eof && i_frame.frame_ok) || // [R10]
     (OUT_MODE == DIO_OUT_DC_SYNC_PULSE_ZERO && DC_ENABLED && dc_sync_pulse_zero_s) || // [R11]
     (OUT_MODE == DIO_OUT_DC_SYNC_PULSE_ONE && DC_ENABLED && dc_sync_pulse_one_s)); // [R11]

  logic [DIO_MAX_BYTES-1:0] is_out;
  logic [DIO_MAX_BYTES-1:0] is_in;
  assign is_out = BYTE_IS_OUT & BYTE_USED; // [R6]
  assign is_in = ~BYTE_IS_OUT & BYTE_USED; // [R6]

  logic [8*DIO_MAX_BYTES-1:0] out_q;
  logic [8*DIO_MAX_BYTES-1:0] in_q;

  genvar b;
  generate
    for (b = 0; b < DIO_MAX_BYTES; b++)
    begin : g_byte
      // output bytes hold between triggers; input capture skips them
      dio_byte_reg u_out (
        .i_clk   (i_clk),
        .i_rst_b (i_rst_b),
        .i_load  (update & is_out[b]), // [R13]
        .i_data  (i_frame_out_data[8*b +: 8]),
        .o_data  (out_q[8*b +: 8])
      );
      dio_byte_reg u_in (
        .i_clk   (i_clk),
        .i_rst_b (i_rst_b),
        .i_load  (capture & is_in[b]), // [R13]
        .i_data  (pin_s[8*b +: 8]),
        .o_data  (in_q[8*b +: 8])
      );
      assign o_pin[8*b +: 8] = is_out[b] ? out_q[8*b +: 8] : 8'h00;
      assign o_pin_oe[b] = is_out[b] & DIO_ACTIVE;
      assign o_frame_in_data[8*b +: 8] = in_q[8*b +: 8];
    end
  endgenerate

  logic [8*DIO_GP_MAX_BYTES-1:0] gp_mask;
  assign gp_mask = (GP_BYTES >= DIO_GP_MAX_BYTES) ? '1 :
                   (8*DIO_GP_MAX_BYTES)'((64'h1 << (8*GP_BYTES)) - 64'h1); // [R2]

  // gp i/o works for any interface selection, also none
  always_ff @(posedge i_clk or negedge i_rst_b)
  begin
    if (!i_rst_b)
    begin
      o_gp_in_data <= '0;
      o_gp_out <= '0;
    end
    else
    begin
      o_gp_in_data <= gp_s & gp_mask; // [R3] [R4]
      o_gp_out <= i_gp_out_data & gp_mask; // [R2]
    end
  end

  always_ff @(posedge i_clk or negedge i_rst_b)
  begin
    if (!i_rst_b)
    begin
      o_in_captured <= 1'b0;
      o_out_updated <= 1'b0;
      o_emul_cfg <= 8'h00;
    end
    else
    begin
      o_in_captured <= capture;
      o_out_updated <= update;
      o_emul_cfg <= {7'h00, DEVICE_EMUL}; // [R12]
    end
  end
endmodule

// File: sim/dio_port_sva.sv
// checker: port assertions for the digital i/o port
`timescale 1ns/1ps
module dio_port_sva
  import dio_pkg::*;
(
  input wire logic                i_clk,
  input wire logic                i_rst_b,
  input wire dio_pkg::dio_frame_t i_frame,
  input wire logic [31:0]         i_frame_out_data,
  input wire logic [31:0]         o_pin,
  input wire logic [3:0]          o_pin_oe,
  input wire logic [31:0]         o_frame_in_data,
  input wire logic                o_in_captured,
  input wire logic                o_out_updated,
  input wire logic [63:0]         i_gp_out_data,
  input wire logic [63:0]         o_gp_out,
  input wire logic [7:0]          o_emul_cfg
);
  wire logic eof_ok = i_frame.eof && i_frame.frame_ok;
  default clocking @(posedge i_clk); endclocking
  default disable iff (!i_rst_b);
  a_out_load: assert property (eof_ok |=> o_pin[31:24] == $past(i_frame_out_data[31:24])
    && o_out_updated) else $error("output byte not loaded");
  a_out_hold: assert property (!eof_ok |=> $stable(o_pin)) else $error("output moved");
  a_out_cause: assert property (o_out_updated |-> $past(eof_ok))
    else $error("stray update pulse");
  a_in_pulse: assert property (i_frame.insert_soon |=> o_in_captured)
    else $error("no capture pulse");
  a_in_hold: assert property (!i_frame.insert_soon |=> $stable(o_frame_in_data))
    else $error("inputs moved");
  a_in_cause: assert property (o_in_captured |-> $past(i_frame.insert_soon))
    else $error("stray capture pulse");
  a_byte_dirs: assert property (o_pin_oe == 4'h8 && o_pin[23:0] == 24'h0
    && o_frame_in_data[31:24] == 8'h00) else $error("byte direction");
  a_gp_out: assert property (1'b1 |=> o_gp_out == $past(i_gp_out_data))
    else $error("gp output");
  a_emul_img: assert property (o_emul_cfg == 8'h00) else $error("emulation bit");
endmodule
bind dio_port dio_port_sva u_sva (.i_clk(i_clk), .i_rst_b(i_rst_b), .i_frame(i_frame),
  .i_frame_out_data(i_frame_out_data), .o_pin(o_pin), .o_pin_oe(o_pin_oe),
  .o_frame_in_data(o_frame_in_data), .o_in_captured(o_in_captured),
  .o_out_updated(o_out_updated), .i_gp_out_data(i_gp_out_data), .o_gp_out(o_gp_out),
  .o_emul_cfg(o_emul_cfg));

// File: sim/dio_app.sv
// application side model driving the digital input pins
`timescale 1ns/1ps
module dio_app (
  input  wire logic [31:0] i_value,
  input  wire logic [31:0] i_port_out,
  input  wire logic [3:0]  i_oe,
  output logic      [31:0] o_pin,
  output logic             o_strobe
);
  // port-driven bytes read back inverted so a stale value never passes
  always_comb
    for (int b = 0; b < 4; b++)
      o_pin[8*b+:8] = i_oe[b] ? ~i_port_out[8*b+:8] : i_value[8*b+:8];
  assign o_strobe = 1'b0; // the application owns strobe timing; idle in this mode
endmodule

// File: sim/tb_digital_io_process_data_port.sv
// self-checking bench for the digital i/o port
`timescale 1ns/1ps
module tb_digital_io_process_data_port;
  import dio_pkg::*;
  logic        i_clk = 1'b0;
  logic        i_rst_b = 1'b0;
  logic        strobe;
  logic        in_cap;
  logic        out_upd;
  dio_frame_t  frame = '0;
  logic [31:0] pin;
  logic [31:0] app_val = 32'h0;
  logic [31:0] fo_data = 32'h0;
  logic [31:0] o_pin;
  logic [31:0] fin;
  logic [31:0] lf = 32'h3081;
  logic [63:0] gpo = 64'h0;
  logic [3:0]  oe;
  logic [63:0] gp_in_seen;
  logic [63:0] gp_out_seen;
  logic [7:0]  emul_seen;
  logic [31:0] qi[$];
  logic [31:0] qo[$];
  int          fails = 0;
  int          checks_done = 0;
  always #2.5 i_clk = ~i_clk;
  dio_app app (.i_value(app_val), .i_port_out(o_pin), .i_oe(oe), .o_pin(pin),
    .o_strobe(strobe));
  dio_port dut (.i_clk(i_clk), .i_rst_b(i_rst_b), .i_frame(frame), .i_sync(2'b00),
    .i_external_input_capture_strobe(strobe), .i_pin(pin), .i_frame_out_data(fo_data),
    .o_pin(o_pin), .o_pin_oe(oe), .o_frame_in_data(fin), .o_in_captured(in_cap),
    .o_out_updated(out_upd), .i_gp_in(gpo), .i_gp_out_data(gpo), .o_gp_in_data(gp_in_seen),
    .o_gp_out(gp_out_seen), .o_emul_cfg(emul_seen));
  function automatic logic [31:0] nx(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    checks_done++;
    if (g !== e)
    begin
      fails++;
      $display("MISMATCH %s exp %h got %h", n, e, g);
    end
  endtask
  task automatic complete_run;
    $display("checks %0d mismatches %0d", checks_done, fails);
    if (fails == 0 && checks_done > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  // look mid-cycle so registered outputs are settled, away from the launching edge
  always @(negedge i_clk)
  begin
    if (in_cap === 1'b1)
      chk("captured inputs", qi.size() ? qi.pop_front() : 'x, fin);
    if (out_upd === 1'b1)
      chk("output pins", qo.size() ? qo.pop_front() : 'x, o_pin);
  end
  initial
  begin
    repeat (8) @(posedge i_clk);
    #1 i_rst_b = 1'b1;
    // capture and update share a cycle; even frames carry a bad frame flag
    for (int t = 0; t < 8; t++)
    begin
      lf = nx(lf);
      app_val = lf;
      repeat (6) @(posedge i_clk);
      #1;
      chk("gp outputs", gpo, gp_out_seen);
      chk("gp inputs", gpo, gp_in_seen);
      chk("emulation image", 32'h0, {24'h0, emul_seen});
      lf = nx(lf);
      fo_data = lf;
      gpo = {lf, ~lf};
      frame.insert_soon = 1'b1;
      frame.eof = 1'b1;
      frame.frame_ok = t[0];
      qi.push_back({8'h00, app_val[23:0]});
      if (t[0])
        qo.push_back({fo_data[31:24], 24'h0});
      @(posedge i_clk);
      #1 frame = '0;
      $display("test %0d done", t);
    end
    for (int w = 0; w < 20 && (qi.size() || qo.size()); w++)
      @(posedge i_clk);
    if (qi.size() || qo.size())
      fails++;
    complete_run;
  end
endmodule
